// ==== access_timer.sv ====
`timescale 1ns/100ps
module access_timer
  import adc_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [TIMER_W-1:0] length,
  output logic active,
  output logic last
);

  logic [TIMER_W-1:0] cnt_reg;
  logic [TIMER_W-1:0] cnt_next;

  // Counts down one access; active covers exactly length cycles.
  always_comb begin
    if (load) begin
      cnt_next = length;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - TIMER_W'(1);
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign active = (cnt_reg != '0);
  assign last = (cnt_reg == TIMER_W'(1));

endmodule

// ==== adc_conv_model.sv ====
`timescale 1ns/100ps
module adc_conv_model #(
  parameter int CONV_CYC = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic writeNode,
  input wire logic [7:0] anaIn,
  input wire logic [3:0] extraWait,
  output logic conversion_done_n,
  output logic [7:0] busDataIn
);
  logic [7:0] result;
  logic [7:0] lastOut = 8'h00;
  logic wrPrev, rdPrev, wrAct, rdAct;
  int count;
  assign wrAct = !writeNode && !chipSelect_n;
  assign rdAct = !readStrobe_n && !chipSelect_n;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 0;
      conversion_done_n <= 1'b1;
      wrPrev <= 1'b0;
      rdPrev <= 1'b0;
      result <= 8'h00;
    end else begin
      wrPrev <= wrAct;
      rdPrev <= rdAct;
      if (wrAct) begin
        conversion_done_n <= 1'b1;
        count <= 0;
      end else if (wrPrev) begin
        count <= CONV_CYC + int'(extraWait);
      end else if (count == 1) begin
        result <= anaIn;
        conversion_done_n <= 1'b0;
        count <= 0;
      end else if (count > 1) begin
        count <= count - 1;
      end
      if (rdAct && !rdPrev) begin
        conversion_done_n <= 1'b1;
      end
    end
  end
  always @(posedge core_clk) begin
    if (rdAct) begin
      lastOut <= result;
    end
  end
  assign busDataIn = rdAct ? result : ~lastOut;
endmodule

// ==== adc_host_bus_interface.sv ====
`timescale 1ns/100ps
module adc_host_bus_interface
  import adc_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic startBurst,
  input wire logic [2:0] modeSel,
  input wire logic [7:0] muxSel,
  input wire logic [3:0] sampleIndex,
  output logic [7:0] sampleData,
  output logic busy,
  output logic burstDone,
  output logic [15:0] hostAddr,
  output logic address_valid,
  output logic chipSelect_n,
  output logic readStrobe_n,
  output logic writeStrobe_n,
  output logic writeStrobeOe,
  output logic memory_request_n,
  output logic port_request_n,
  output logic memory_read_strobe_n,
  output logic memory_write_strobe_n,
  output logic portReadStrobe_n,
  output logic portWriteStrobe_n,
  output logic rwLine,
  output logic phaseTwo,
  output logic mcuPortBit0,
  output logic [7:0] muxChannel,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  input wire logic [7:0] busDataIn,
  input wire logic conversion_done_n
);

  state_e state_reg;
  state_e state_next;
  mode_e mode_reg;
  mode_e mode_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [7:0] mux_reg;
  logic [7:0] mux_next;
  logic [7:0] sample_reg;
  logic [7:0] sample_next;
  logic [7:0] mem_reg [SAMPLES];
  logic done_reg;
  logic done_next;
  logic timerLoad;
  logic [TIMER_W-1:0] timerLen;
  logic accActive;
  logic accLast;
  logic phaseTick;
  logic phaseLevel;
  logic isPort;
  logic genRd_n;
  logic genWr_n;
  logic rdAccess;
  logic wrAccess;
  logic capture;
  logic [7:0] rdHold_reg;
  logic [7:0] rdHold_next;

  clk_enable_div #(.DIV(PHASE_DIV)) u_phase (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(phaseTick),
    .phase(phaseLevel)
  );

  access_timer u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(timerLoad),
    .length(timerLen),
    .active(accActive),
    .last(accLast)
  );

  assign isPort = (mode_reg == MODE_PORT) || (mode_reg == MODE_ONEHOT);

  // Sequencer for a burst of start, wait for done and read.
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    count_next = count_reg;
    addr_next = addr_reg;
    done_next = 1'b0;
    timerLoad = 1'b0;
    timerLen = TIMER_W'(STROBE_CYC);
    capture = 1'b0;
    if (isPort) begin
      timerLen = TIMER_W'(STROBE_CYC + WAIT_STATES);
    end
    case (state_reg)
      ST_IDLE: begin
        if (startBurst) begin
          mode_next = mode_e'(modeSel);
          count_next = 4'h0;
          timerLoad = 1'b1;
          timerLen = (mode_next == MODE_PORT || mode_next == MODE_ONEHOT) ?
            TIMER_W'(STROBE_CYC + WAIT_STATES) : TIMER_W'(STROBE_CYC);
          if (mode_e'(modeSel) == MODE_FREE) begin
            timerLen = TIMER_W'(KICK_CYC);
            state_next = ST_KICK;
          end else begin
            state_next = ST_START;
          end
        end
      end
      ST_KICK: begin
        if (accLast) begin
          state_next = ST_WAIT;
        end
      end
      ST_START: begin
        if (accLast) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!conversion_done_n) begin
          timerLoad = 1'b1;
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (accLast) begin
          capture = 1'b1;
          count_next = count_reg + 4'h1;
          if (count_reg == 4'(SAMPLES - 1)) begin
            state_next = ST_FINISH;
          end else if (mode_reg == MODE_FREE) begin
            state_next = ST_WAIT;
          end else begin
            timerLoad = 1'b1;
            state_next = ST_START;
          end
        end
      end
      ST_FINISH: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Address presented for the access that the sequencer enters next.
    case (mode_next)
      MODE_MEM: addr_next = MEM_ADDR;
      MODE_RW: addr_next = MEM_ADDR;
      MODE_PORT: addr_next = {PORT_NUM, PORT_NUM};
      MODE_ONEHOT: addr_next = {ONEHOT_PORT, ONEHOT_PORT};
      MODE_MCU: addr_next = DUMMY_ADDR;
      MODE_ADAPTER: addr_next = ADAPTER_CTRL;
      default: addr_next = 16'h0000;
    endcase
    if (state_next == ST_READ) begin
      if (isPort) begin
        addr_next[15:8] = muxSel;
      end
      if (mode_reg == MODE_ADAPTER) begin
        addr_next = ADAPTER_DATA;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_MEM;
      count_reg <= 4'h0;
      addr_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      done_reg <= done_next;
    end
  end

  // Generic strobes and the phase-two gate of the read/not-write bus.
  always_comb begin
    rdAccess = (state_reg == ST_READ) && accActive;
    wrAccess = (state_reg == ST_START) && accActive;
    genRd_n = ~rdAccess;
    genWr_n = ~wrAccess;
    if (mode_reg == MODE_RW) begin
      genRd_n = ~(rdAccess && phaseLevel);
      genWr_n = ~(wrAccess && phaseLevel);
    end
  end

  assign address_valid = rdAccess || wrAccess;
  assign memory_request_n =
    ~(address_valid && (mode_reg == MODE_MEM || mode_reg == MODE_RW));
  assign port_request_n = ~(address_valid && isPort);
  assign memory_read_strobe_n = memory_request_n | genRd_n;
  assign memory_write_strobe_n = memory_request_n | genWr_n;
  assign portReadStrobe_n = port_request_n | genRd_n;
  assign portWriteStrobe_n = port_request_n | genWr_n;
  assign rwLine = (state_reg != ST_START);
  assign phaseTwo = phaseLevel;
  assign mcuPortBit0 = ~(mode_reg == MODE_MCU && busy);

  // Chip-select for each way of attaching the converter.
  always_comb begin
    case (mode_reg)
      MODE_MEM:
        chipSelect_n = ~(address_valid && addr_reg == MEM_ADDR);
      MODE_RW:
        chipSelect_n =
          ~(address_valid && addr_reg[15:13] == RANGE_TOP);
      MODE_PORT:
        chipSelect_n = ~(address_valid && addr_reg[7:0] == PORT_NUM);
      MODE_ONEHOT:
        chipSelect_n = ~address_valid | addr_reg[ONEHOT_BIT];
      MODE_MCU: chipSelect_n = mcuPortBit0;
      default: chipSelect_n = 1'b0;
    endcase
  end

  assign readStrobe_n = (mode_reg == MODE_ADAPTER) ? 1'b0 : genRd_n;
  assign writeStrobe_n =
    (state_reg == ST_KICK) ? 1'b0 : genWr_n;
  assign writeStrobeOe =
    (mode_reg == MODE_FREE) ? (state_reg == ST_KICK) : 1'b1;

  // Mux channel latch and sample store.
  always_comb begin
    mux_next = mux_reg;
    sample_next = mem_reg[sampleIndex];
    rdHold_next = (!readStrobe_n && !chipSelect_n) ? busDataIn : rdHold_reg;
    if (!portReadStrobe_n) begin
      mux_next = addr_reg[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mux_reg <= 8'h00;
      sample_reg <= 8'h00;
      rdHold_reg <= 8'h00;
    end else begin
      mux_reg <= mux_next;
      sample_reg <= sample_next;
      rdHold_reg <= rdHold_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (capture) begin
      mem_reg[count_reg] <= rdHold_next;
    end
  end

  assign muxChannel = mux_reg;
  assign sampleData = sample_reg;
  assign busy = (state_reg != ST_IDLE);
  assign burstDone = done_reg;
  assign hostAddr = addr_reg;
  assign busDataOut = (mode_reg == MODE_ADAPTER) ? CTRL_START : CTRL_IDLE;
  assign busDataOe = wrAccess && (mode_reg == MODE_ADAPTER);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence readEnd;
    state_reg == ST_READ && accLast && count_reg != 4'hF;
  endsequence

  sequence stretched;
    (accActive && !accLast) [*4] ##1 accLast;
  endsequence

  a_restart_next: assert property (
    readEnd ##0 (mode_reg != MODE_FREE) |=> state_reg == ST_START)
    else $error("No restart after read.");

  a_wait_stretch: assert property (
    isPort && $rose(accActive) |-> stretched)
    else $error("Port access not stretched.");

  a_plain_length: assert property (
    mode_reg == MODE_MEM && $rose(accActive) |->
    (accActive && !accLast) [*3] ##1 accLast)
    else $error("Memory access length wrong.");

  a_kick_pulse: assert property (
    $rose(state_reg == ST_KICK) |-> (!writeStrobe_n && writeStrobeOe) [*6]
    ##1 !writeStrobeOe)
    else $error("Startup pulse wrong.");

  a_mem_valid: assert property (
    mode_reg == MODE_MEM && !chipSelect_n |-> address_valid
    && hostAddr == MEM_ADDR)
    else $error("Chip-select without valid address.");

  a_port_addr: assert property (
    !portWriteStrobe_n && mode_reg == MODE_PORT |->
    hostAddr == {PORT_NUM, PORT_NUM})
    else $error("Port number not repeated.");

  a_strobe_pair: assert property (
    !memory_read_strobe_n |-> !memory_request_n && readStrobe_n == 1'b0
    && port_request_n)
    else $error("Memory strobe pairing wrong.");

  a_rw_phase: assert property (
    mode_reg == MODE_RW && !readStrobe_n |-> phaseTwo && rwLine)
    else $error("Read outside phase two.");

  a_adapter_tie: assert property (
    mode_reg == MODE_ADAPTER && busy |-> !chipSelect_n && !readStrobe_n)
    else $error("Adapter lines not tied low.");

  a_mux_latch: assert property (
    !portReadStrobe_n |=> muxChannel == $past(muxSel))
    else $error("Mux channel not latched.");

endmodule

// ==== adc_host_pkg.sv ====
package adc_host_pkg;

  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_STATES = 1;
  localparam int KICK_NS = 300;
  localparam int KICK_CYC = (KICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHASE_DIV = 2;
  localparam int SAMPLES = 16;
  localparam int TIMER_W = 4;

  localparam logic [7:0] PORT_NUM = 8'hE0;
  localparam logic [15:0] MEM_ADDR = 16'h5000;
  localparam logic [2:0] RANGE_TOP = 3'h2;
  localparam logic [15:0] ADAPTER_DATA = 16'h8006;
  localparam logic [15:0] ADAPTER_CTRL = 16'h8007;
  localparam logic [15:0] DUMMY_ADDR = 16'h00FF;
  localparam int ONEHOT_BIT = 3;
  localparam logic [7:0] ONEHOT_PORT = 8'hF7;
  localparam logic [7:0] CTRL_START = 8'h34;
  localparam logic [7:0] CTRL_IDLE = 8'h3D;

  typedef enum logic [2:0] {
    MODE_MEM = 3'h0,
    MODE_PORT = 3'h1,
    MODE_ONEHOT = 3'h2,
    MODE_MCU = 3'h3,
    MODE_RW = 3'h4,
    MODE_ADAPTER = 3'h5,
    MODE_FREE = 3'h6
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_WAIT = 3'h3,
    ST_READ = 3'h2,
    ST_FINISH = 3'h6,
    ST_KICK = 3'h4
  } state_e;

endpackage

// ==== clk_enable_div.sv ====
`timescale 1ns/100ps
module clk_enable_div
  import adc_host_pkg::*;
#(
  parameter int DIV = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic tick,
  output logic phase
);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic phase_reg;
  logic phase_next;

  // A tick every DIV cycles toggles the slow phase level.
  always_comb begin
    tick = (cnt_reg == 4'(DIV - 1));
    cnt_next = tick ? 4'h0 : cnt_reg + 4'h1;
    phase_next = tick ? ~phase_reg : phase_reg;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      phase_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;

endmodule

// ==== tb_adc_host_bus_interface.sv ====
`timescale 1ns/100ps
module tb_adc_host_bus_interface;
  import adc_host_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic startBurst = 1'b0;
  logic [2:0] modeSel = 3'h0;
  logic [7:0] muxSel = 8'h00;
  logic [3:0] sampleIndex = 4'h0;
  logic [7:0] anaIn = 8'h00;
  logic [3:0] extraWait = 4'h0;
  logic [7:0] sampleData, muxChannel, busDataOut, busDataIn;
  logic [15:0] hostAddr, wAddr;
  logic busy, burstDone, address_valid, chipSelect_n, readStrobe_n;
  logic writeStrobe_n, writeStrobeOe, memory_request_n, port_request_n;
  logic memory_read_strobe_n, memory_write_strobe_n, portReadStrobe_n;
  logic portWriteStrobe_n, rwLine, phaseTwo, mcuPortBit0, busDataOe;
  logic conversion_done_n, writeNode, wPort, wMem, wRw, flagBad;
  int n_mismatch = 0;
  int checked = 0;
  int wl = 0;
  int lastWl = 0;
  int curMode = 0;
  logic [7:0] exp[$];
  always #25 core_clk = ~core_clk;
  assign writeNode = writeStrobeOe ? writeStrobe_n : conversion_done_n;
  adc_host_bus_interface dut_u (
    .core_clk, .nrst, .startBurst, .modeSel, .muxSel, .sampleIndex,
    .sampleData, .busy, .burstDone, .hostAddr, .address_valid,
    .chipSelect_n, .readStrobe_n, .writeStrobe_n, .writeStrobeOe,
    .memory_request_n, .port_request_n, .memory_read_strobe_n,
    .memory_write_strobe_n, .portReadStrobe_n, .portWriteStrobe_n,
    .rwLine, .phaseTwo, .mcuPortBit0, .muxChannel, .busDataOut,
    .busDataOe, .busDataIn, .conversion_done_n
  );
  adc_conv_model conv_u (
    .core_clk, .nrst, .chipSelect_n, .readStrobe_n, .writeNode, .anaIn,
    .extraWait, .conversion_done_n, .busDataIn
  );
  always @(negedge conversion_done_n) begin
    exp.push_back(anaIn);
    #3 anaIn = $urandom;
  end
  always @(posedge core_clk) begin
    if (!writeStrobe_n && writeStrobeOe) begin
      wl <= wl + 1;
      wAddr <= hostAddr;
      wMem <= memory_write_strobe_n;
      wPort <= portWriteStrobe_n;
      wRw <= rwLine;
    end else if (wl != 0) begin
      lastWl <= wl;
      wl <= 0;
    end
    case (curMode)
      0: if (!chipSelect_n && !address_valid) flagBad <= 1'b1;
      3: if (busy && mcuPortBit0) flagBad <= 1'b1;
      5: if (busy && chipSelect_n) flagBad <= 1'b1;
      default: ;
    endcase
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic doReset();
    nrst = 1'b0;
    step(10);
    nrst = 1'b1;
  endtask
  task automatic pulseStart(input logic [2:0] m);
    modeSel = m;
    startBurst = 1'b1;
    step();
    startBurst = 1'b0;
  endtask
  task automatic run(input int m);
    int i;
    curMode = m;
    exp.delete();
    flagBad = 1'b0;
    muxSel = $urandom;
    extraWait = $urandom;
    pulseStart(m[2:0]);
    step(8);
    pulseStart(m[2:0] ^ 3'h1);
    i = 0;
    while (burstDone !== 1'b1 && i < 4000) begin
      step();
      i++;
    end
    check("burstDone", 16'h0001, burstDone);
    step();
    check("busy", 16'h0000, busy);
    check("count", 16'(SAMPLES), 16'(exp.size()));
    for (i = 0; i < SAMPLES; i++) begin
      sampleIndex = i[3:0];
      step();
      check("sample", exp[i], sampleData);
    end
    case (m)
      0: begin
        check("addr", MEM_ADDR, wAddr);
        check("strobes", 16'h0001, {wMem, wPort});
      end
      1: begin
        check("port", PORT_NUM, wAddr[7:0]);
        check("strobes", 16'h0002, {wMem, wPort});
        check("mux", muxSel, muxChannel);
      end
      2: check("onehot", ONEHOT_PORT, wAddr[7:0]);
      3: check("dummy", DUMMY_ADDR, wAddr);
      4: check("rw", 16'h0000, wRw);
      5: check("ctrl", ADAPTER_CTRL, wAddr);
      default: ;
    endcase
    if (m < 4) begin
      check("len", (m == 1 || m == 2) ? STROBE_CYC + WAIT_STATES :
            STROBE_CYC, lastWl);
    end
    check("flags", 16'h0000, flagBad);
    $display("test mode %0d done", m);
  endtask
  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    anaIn = $urandom(85774);
    doReset();
    check("busy", 16'h0000, busy);
    check("cs", 16'h0001, chipSelect_n);
    check("done", 16'h0000, burstDone);
    check("hostAddr", 16'h0000, hostAddr);
    check("oe", 16'h0001, writeStrobeOe);
    for (int m = 0; m < 6; m++) begin
      run(m);
    end
    curMode = 6;
    exp.delete();
    pulseStart(3'h6);
    step(400);
    check("kick", 16'(KICK_CYC), 16'(lastWl));
    check("freerun", 16'h0001, 16'(exp.size() > 2));
    check("cs", 16'h0000, chipSelect_n);
    $display("test mode 6 done");
    doReset();
    check("busy", 16'h0000, busy);
    results();
  end
  initial begin
    #(50 * 40000);
    n_mismatch++;
    results();
  end
endmodule
